// ===== dasd_defs.svh
`ifndef DASD_DEFS_SVH
`define DASD_DEFS_SVH
// ==========================================================
// space bounds
`define DASD_RAM_TOP 8'h7F
`define DASD_BIT_RAM_BASE 8'h20
`define DASD_UNDEF_BYTE 8'hFF
// ==========================================================
// hardware register addresses
`define DASD_TMR_CTL_ADDR 8'h88
`define DASD_PORT_ONE_ADDR 8'h90
`define DASD_SER_CTL_ADDR 8'h98
`define DASD_IRQ_EN_ADDR 8'hA8
`define DASD_PORT_THREE_ADDR 8'hB0
`define DASD_IRQ_LVL_ADDR 8'hB8
`define DASD_STATUS_ADDR 8'hD0
// ==========================================================
// status word fields
`define DASD_CARRY_POS 7
`define DASD_AUX_CARRY_POS 6
`define DASD_USER_FLAG_POS 5
`define DASD_BANK_HIGH_POS 4
`define DASD_BANK_LOW_POS 3
`define DASD_SIGNED_ERR_POS 2
`define DASD_PARITY_POS 0
// ==========================================================
// timer control fields
`define DASD_TMR1_OVF_POS 7
`define DASD_TMR1_RUN_POS 6
`define DASD_TMR0_OVF_POS 5
`define DASD_TMR0_RUN_POS 4
`define DASD_EXT1_EDGE_POS 3
`define DASD_EXT1_TYPE_POS 2
`define DASD_EXT0_EDGE_POS 1
`define DASD_EXT0_TYPE_POS 0
// ==========================================================
// serial control fields, modes in 7..5
`define DASD_RX_ENABLE_POS 4
`define DASD_TX_NINTH_POS 3
`define DASD_RX_NINTH_POS 2
`define DASD_TX_DONE_POS 1
`define DASD_RX_DONE_POS 0
// ==========================================================
// enable/level fields, global gate only in enable byte
`define DASD_GLOBAL_GATE_POS 7
`define DASD_SERIAL_IRQ_POS 4
`define DASD_TMR1_IRQ_POS 3
`define DASD_EXT1_IRQ_POS 2
`define DASD_TMR0_IRQ_POS 1
`define DASD_EXT0_IRQ_POS 0
// ==========================================================
// port three alternate functions
`define DASD_ALT_RD_POS 7
`define DASD_ALT_WR_POS 6
`define DASD_ALT_CNT1_POS 5
`define DASD_ALT_CNT0_POS 4
`define DASD_ALT_EXT1_POS 3
`define DASD_ALT_EXT0_POS 2
`define DASD_ALT_TXD_POS 1
`define DASD_ALT_RXD_POS 0
// ==========================================================
// reset values
`define DASD_RST_BYTE 8'h00
`define DASD_RST_PORT 8'hFF
`endif

// ===== dasd_pkg.sv
`default_nettype none
package dasd_pkg;
    typedef enum logic [2:0] {
        DASD_DIRECT = 3'h0,
        DASD_INDIRECT = 3'h1,
        DASD_BIT = 3'h2,
        DASD_CODE_TABLE_READ = 3'h3,
        DASD_EXTERNAL_DATA_MOVE = 3'h4
    } dasd_kind_e;

    typedef struct packed {
        logic [127:0][7:0] ram;
        logic [7:0] program_status_word;
        logic [7:0] timer_control_byte;
        logic [7:0] serial_control_byte;
        logic [7:0] interrupt_enable_mask;
        logic [7:0] interrupt_level_select;
        logic [7:0] port_one_latch;
        logic [7:0] port_three_latch;
        logic [7:0] port3_meta;
        logic [7:0] port3_sync;
        logic [7:0] port3_drive;
        logic [7:0] rsp_rdata;
        logic [7:0] ext_addr;
        logic rsp_valid;
        logic rsp_bit;
        logic ext_code_stb;
        logic ext_data_stb;
    } dasd_state_s;
endpackage
`default_nettype wire

// ===== dasd_decoder.sv
`include "dasd_defs.svh"
`default_nettype none
module dasd_decoder
    import dasd_pkg::*;
#(
    parameter logic [7:0] UNDEF_BYTE = `DASD_UNDEF_BYTE,
    parameter int BANK_COUNT = 4
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic [2:0] req_kind,
    input wire logic req_write,
    input wire logic req_ptr_sel,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_wbit,
    input wire logic timer1_overflow_set,
    input wire logic timer0_overflow_set,
    input wire logic ext1_edge_set,
    input wire logic ext0_edge_set,
    input wire logic transmit_done_set,
    input wire logic receive_done_set,
    input wire logic alt_read_strobe_n,
    input wire logic alt_write_strobe_n,
    input wire logic alt_serial_tx,
    input wire logic [7:0] port_three_pins_in,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_bit,
    output logic ext_code_stb,
    output logic ext_data_stb,
    output logic [7:0] ext_addr,
    output logic [1:0] active_bank,
    output logic [7:0] program_status_word,
    output logic [7:0] timer_control_byte,
    output logic [7:0] serial_control_byte,
    output logic [7:0] interrupt_enable_mask,
    output logic [7:0] interrupt_level_select,
    output logic [7:0] port_one_latch,
    output logic [7:0] port_three_latch,
    output logic [7:0] port_three_pins_out,
    output logic counter1_input,
    output logic counter0_input,
    output logic ext1_request_pin,
    output logic ext0_request_pin,
    output logic serial_rx_pin
);

    // ==========================================================
    // elaboration check
    generate
        if (BANK_COUNT != 4)
        begin : g_bank_check
            $error("dasd_decoder serves exactly four register banks");
        end
    endgenerate

    // ==========================================================
    // helpers
    function automatic logic sfr_defined(input logic [7:0] a);
        unique case (a)
            `DASD_TMR_CTL_ADDR, `DASD_PORT_ONE_ADDR, `DASD_SER_CTL_ADDR,
            `DASD_IRQ_EN_ADDR, `DASD_PORT_THREE_ADDR, `DASD_IRQ_LVL_ADDR,
            `DASD_STATUS_ADDR: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction

    function automatic logic [7:0] sfr_get(input dasd_state_s s, input logic [7:0] a);
        unique case (a)
            `DASD_TMR_CTL_ADDR: return s.timer_control_byte;
            `DASD_PORT_ONE_ADDR: return s.port_one_latch;
            `DASD_SER_CTL_ADDR: return s.serial_control_byte;
            `DASD_IRQ_EN_ADDR: return s.interrupt_enable_mask;
            `DASD_PORT_THREE_ADDR: return s.port_three_latch;
            `DASD_IRQ_LVL_ADDR: return s.interrupt_level_select;
            `DASD_STATUS_ADDR: return s.program_status_word;
            default: return UNDEF_BYTE;
        endcase
    endfunction

    // reserved addresses fall through untouched
    function automatic dasd_state_s sfr_put(input dasd_state_s s, input logic [7:0] a,
                                            input logic [7:0] v);
        dasd_state_s r;
        r = s;
        unique case (a)
            `DASD_TMR_CTL_ADDR: r.timer_control_byte = v;
            `DASD_PORT_ONE_ADDR: r.port_one_latch = v;
            `DASD_SER_CTL_ADDR: r.serial_control_byte = v;
            `DASD_IRQ_EN_ADDR: r.interrupt_enable_mask = v;
            `DASD_PORT_THREE_ADDR: r.port_three_latch = v;
            `DASD_IRQ_LVL_ADDR: r.interrupt_level_select = v;
            `DASD_STATUS_ADDR: r.program_status_word = v;
            default: r = s;
        endcase
        return r;
    endfunction

    // byte holding a bit address
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        if (a <= `DASD_RAM_TOP)
            return `DASD_BIT_RAM_BASE + {4'h0, a[6:3]};
        return {a[7:3], 3'h0};
    endfunction

    // ==========================================================
    // state
    dasd_state_s st_q;
    dasd_state_s st_d;
    dasd_kind_e kind;
    logic [1:0] bank;
    logic [6:0] ptr_idx;
    logic [7:0] ptr_val;
    logic [7:0] bb_addr;
    logic [7:0] bb_val;

    always_comb
    begin
        st_d = st_q;
        kind = dasd_kind_e'(req_kind);
        st_d.rsp_valid = 1'h0;
        st_d.ext_code_stb = 1'h0;
        st_d.ext_data_stb = 1'h0;
        st_d.port3_meta = port_three_pins_in;
        st_d.port3_sync = st_q.port3_meta;
        bank = {st_q.program_status_word[`DASD_BANK_HIGH_POS],
                st_q.program_status_word[`DASD_BANK_LOW_POS]};
        // register zero of bank n at byte 8n, pointer one right after
        ptr_idx = {2'h0, bank, 2'h0, req_ptr_sel};
        // current contents, so an earlier value never leaks in
        ptr_val = st_q.ram[ptr_idx];
        bb_addr = bit_byte(req_addr);
        bb_val = (bb_addr <= `DASD_RAM_TOP) ? st_q.ram[bb_addr[6:0]]
                                            : sfr_get(st_q, bb_addr);
        if (req_valid)
        begin
            unique case (kind)
                DASD_DIRECT:
                begin
                    st_d.rsp_valid = !req_write;
                    if (req_addr <= `DASD_RAM_TOP)
                    begin
                        st_d.rsp_rdata = st_q.ram[req_addr[6:0]];
                        if (req_write)
                            st_d.ram[req_addr[6:0]] = req_wdata;
                    end
                    else
                    begin
                        st_d.rsp_rdata = sfr_get(st_q, req_addr);
                        if (req_write)
                            st_d = sfr_put(st_d, req_addr, req_wdata);
                    end
                end
                DASD_INDIRECT:
                begin
                    st_d.rsp_valid = !req_write;
                    // high pointers stay in indirect space: no register alias
                    if (ptr_val > `DASD_RAM_TOP)
                        st_d.rsp_rdata = UNDEF_BYTE;
                    else
                    begin
                        st_d.rsp_rdata = st_q.ram[ptr_val[6:0]];
                        if (req_write)
                            st_d.ram[ptr_val[6:0]] = req_wdata;
                    end
                end
                DASD_BIT:
                begin
                    st_d.rsp_valid = !req_write;
                    st_d.rsp_rdata = bb_val;
                    st_d.rsp_bit = bb_val[req_addr[2:0]];
                    if (req_write)
                    begin
                        bb_val[req_addr[2:0]] = req_wbit;
                        if (bb_addr <= `DASD_RAM_TOP)
                            st_d.ram[bb_addr[6:0]] = bb_val;
                        else
                            st_d = sfr_put(st_d, bb_addr, bb_val);
                    end
                end
                DASD_CODE_TABLE_READ:
                begin
                    st_d.ext_code_stb = 1'h1;
                    st_d.ext_addr = ptr_val;
                end
                DASD_EXTERNAL_DATA_MOVE:
                begin
                    st_d.ext_data_stb = 1'h1;
                    st_d.ext_addr = ptr_val;
                end
                default:
                begin
                    st_d.rsp_valid = 1'h0;
                end
            endcase
        end
        // hardware sets come last so they win over a clearing write
        if (timer1_overflow_set)
            st_d.timer_control_byte[`DASD_TMR1_OVF_POS] = 1'h1;
        if (timer0_overflow_set)
            st_d.timer_control_byte[`DASD_TMR0_OVF_POS] = 1'h1;
        if (ext1_edge_set)
            st_d.timer_control_byte[`DASD_EXT1_EDGE_POS] = 1'h1;
        if (ext0_edge_set)
            st_d.timer_control_byte[`DASD_EXT0_EDGE_POS] = 1'h1;
        if (transmit_done_set)
            st_d.serial_control_byte[`DASD_TX_DONE_POS] = 1'h1;
        if (receive_done_set)
            st_d.serial_control_byte[`DASD_RX_DONE_POS] = 1'h1;
        // a latch bit of one lets the alternate function through
        st_d.port3_drive = st_d.port_three_latch;
        st_d.port3_drive[`DASD_ALT_RD_POS] = st_d.port_three_latch[`DASD_ALT_RD_POS]
                                             & alt_read_strobe_n;
        st_d.port3_drive[`DASD_ALT_WR_POS] = st_d.port_three_latch[`DASD_ALT_WR_POS]
                                             & alt_write_strobe_n;
        st_d.port3_drive[`DASD_ALT_TXD_POS] = st_d.port_three_latch[`DASD_ALT_TXD_POS]
                                              & alt_serial_tx;
        if (!nrst)
        begin
            st_d = '0;
            st_d.port_one_latch = `DASD_RST_PORT;
            st_d.port_three_latch = `DASD_RST_PORT;
            st_d.port3_drive = `DASD_RST_PORT;
            st_d.program_status_word = `DASD_RST_BYTE;
        end
    end

    always_ff @(posedge core_clk)
    begin
        st_q <= st_d;
    end

    // ==========================================================
    // outputs
    assign rsp_valid = st_q.rsp_valid;
    assign rsp_rdata = st_q.rsp_rdata;
    assign rsp_bit = st_q.rsp_bit;
    assign ext_code_stb = st_q.ext_code_stb;
    assign ext_data_stb = st_q.ext_data_stb;
    assign ext_addr = st_q.ext_addr;
    assign active_bank = {st_q.program_status_word[`DASD_BANK_HIGH_POS],
                          st_q.program_status_word[`DASD_BANK_LOW_POS]};
    assign program_status_word = st_q.program_status_word;
    assign timer_control_byte = st_q.timer_control_byte;
    assign serial_control_byte = st_q.serial_control_byte;
    assign interrupt_enable_mask = st_q.interrupt_enable_mask;
    assign interrupt_level_select = st_q.interrupt_level_select;
    assign port_one_latch = st_q.port_one_latch;
    assign port_three_latch = st_q.port_three_latch;
    assign port_three_pins_out = st_q.port3_drive;
    // pin alternates read only the second synchroniser stage
    assign counter1_input = st_q.port3_sync[`DASD_ALT_CNT1_POS];
    assign counter0_input = st_q.port3_sync[`DASD_ALT_CNT0_POS];
    assign ext1_request_pin = st_q.port3_sync[`DASD_ALT_EXT1_POS];
    assign ext0_request_pin = st_q.port3_sync[`DASD_ALT_EXT0_POS];
    assign serial_rx_pin = st_q.port3_sync[`DASD_ALT_RXD_POS];

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_ind(logic wr);
        req_valid && kind == DASD_INDIRECT && req_write == wr;
    endsequence

    sequence s_direct_wr;
        req_valid && kind == DASD_DIRECT && req_write;
    endsequence

    a_ind_high_read: assert property (
        s_ind(1'h0) ##0 (ptr_val > `DASD_RAM_TOP) |=> rsp_valid && rsp_rdata == UNDEF_BYTE)
        else $error("high indirect read not undefined");

    a_ind_high_drop: assert property (
        s_ind(1'h1) ##0 (ptr_val > `DASD_RAM_TOP) |=> st_q.ram == $past(st_q.ram)
        && port_one_latch == $past(port_one_latch)
        && program_status_word == $past(program_status_word))
        else $error("high indirect write changed state");

    a_ind_bank_read: assert property (
        s_ind(1'h0) ##0 (ptr_val <= `DASD_RAM_TOP) |=> rsp_rdata
        == $past(st_q.ram[st_q.ram[{2'h0, active_bank, 2'h0, req_ptr_sel}][6:0]]))
        else $error("indirect read wrong byte");

    a_direct_ram_wr: assert property (
        s_direct_wr ##0 (req_addr <= `DASD_RAM_TOP)
        |=> st_q.ram[$past(req_addr[6:0])] == $past(req_wdata))
        else $error("direct ram write lost");

    // latch must take the byte on the very next edge
    a_port_one_wr: assert property (
        s_direct_wr ##0 (req_addr == `DASD_PORT_ONE_ADDR)
        |=> port_one_latch == $past(req_wdata))
        else $error("port one write missed");

    a_undef_sfr_rd: assert property (
        req_valid && kind == DASD_DIRECT && !req_write && req_addr > `DASD_RAM_TOP
        && !sfr_defined(req_addr) |=> rsp_rdata == UNDEF_BYTE)
        else $error("reserved register read defined");

    a_bit_ram_map: assert property (
        req_valid && kind == DASD_BIT && req_write && req_addr <= `DASD_RAM_TOP
        |=> st_q.ram[$past(`DASD_BIT_RAM_BASE + {4'h0, req_addr[6:3]}) & 8'h7F]
        [$past(req_addr[2:0])] == $past(req_wbit))
        else $error("ram bit write misplaced");

    a_bit_sfr_map: assert property (
        req_valid && kind == DASD_BIT && req_write && req_addr == 8'h8E
        |=> timer_control_byte[`DASD_TMR1_RUN_POS] == $past(req_wbit))
        else $error("register bit write misplaced");

    a_ext_route: assert property (
        req_valid && kind == DASD_CODE_TABLE_READ
        |=> ext_code_stb && !ext_data_stb && ext_addr == $past(ptr_val) ##1 !ext_code_stb
        || $past(req_valid))
        else $error("code table read not routed");

    a_set_wins: assert property (
        (timer1_overflow_set and s_direct_wr) ##0 req_addr == `DASD_TMR_CTL_ADDR
        |=> timer_control_byte[`DASD_TMR1_OVF_POS])
        else $error("hardware set lost to clear");

endmodule
`default_nettype wire

// ===== dasd_core_model.sv
`default_nettype none
// ==========================================================
// instruction core stand-in, one request per call
module dasd_core_model
    import dasd_pkg::*;
(
    input wire logic core_clk,
    output var logic req_valid,
    output var logic [2:0] req_kind,
    output var logic req_write,
    output var logic req_ptr_sel,
    output var logic [7:0] req_addr,
    output var logic [7:0] req_wdata,
    output var logic req_wbit
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        req_valid = 1'b0;
        req_kind = DASD_DIRECT;
        req_write = 1'b0;
        req_ptr_sel = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        req_wbit = 1'b0;
    end

    // calls chain back to back; valid stays up until release_bus
    task automatic issue(input logic [2:0] kind, input logic wr, input logic psel,
                         input logic [7:0] addr, input logic [7:0] wdata, input logic wbit);
        @(negedge core_clk);
        req_valid = 1'b1;
        req_kind = kind;
        req_write = wr;
        req_ptr_sel = psel;
        req_addr = addr;
        req_wdata = wdata;
        req_wbit = wbit;
    endtask

    // address, data and bit fields scrambled so nothing leans on their stale values
    task automatic release_bus();
        @(negedge core_clk);
        req_valid = 1'b0;
        req_addr = ~req_addr;
        req_wdata = ~req_wdata;
        req_wbit = ~req_wbit;
    endtask
endmodule
`default_nettype wire

// ===== data_space_address_decoder_bench.sv
`include "dasd_defs.svh"
`default_nettype none
module data_space_address_decoder_bench
    import dasd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [2:0] flags; logic is_bit; logic [7:0] val;} dasd_note_s;
    localparam logic [2:0] RSP = 3'h4;
    localparam logic [2:0] CODE = 3'h2;
    localparam logic [2:0] XDM = 3'h1;
    localparam logic [7:0] RADDR [6] = '{8'h88, 8'h98, 8'hA8, 8'hB8, 8'hB0, 8'h90};
    localparam logic [7:0] RMASK [6] = '{8'hFF, 8'hFF, 8'h9F, 8'h1F, 8'hFF, 8'hFF};
    localparam logic [7:0] BBASE [5] = '{8'h88, 8'h98, 8'hA8, 8'hB8, 8'hD0};
    localparam logic [7:0] BMASK [5] = '{8'hFF, 8'hFF, 8'h9F, 8'h1F, 8'hFD};
    logic core_clk = 1'b0;
    logic nrst, req_valid, req_write, req_ptr_sel, req_wbit, rsp_valid, rsp_bit;
    logic ext_code_stb, ext_data_stb, counter1_input, counter0_input;
    logic ext1_request_pin, ext0_request_pin, serial_rx_pin;
    logic [2:0] req_kind, alt;
    logic [5:0] fset;
    logic [1:0] active_bank;
    logic [7:0] req_addr, req_wdata, pins, rsp_rdata, ext_addr, port_three_pins_out, seen;
    logic [7:0] program_status_word, timer_control_byte, serial_control_byte;
    logic [7:0] interrupt_enable_mask, interrupt_level_select, port_one_latch, port_three_latch;
    logic [7:0] seed = 8'h2B;
    int miscompares = 0;
    int comparisons = 0;
    dasd_note_s notes[$];
    dasd_note_s note;

    always #50 core_clk = ~core_clk;

    dasd_core_model core (.core_clk(core_clk), .req_valid(req_valid), .req_kind(req_kind),
        .req_write(req_write), .req_ptr_sel(req_ptr_sel), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_wbit(req_wbit));

    dasd_decoder dut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
        .req_kind(req_kind), .req_write(req_write), .req_ptr_sel(req_ptr_sel),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_wbit(req_wbit),
        .timer1_overflow_set(fset[5]), .timer0_overflow_set(fset[4]),
        .ext1_edge_set(fset[3]), .ext0_edge_set(fset[2]), .transmit_done_set(fset[1]),
        .receive_done_set(fset[0]), .alt_read_strobe_n(alt[2]), .alt_write_strobe_n(alt[1]),
        .alt_serial_tx(alt[0]), .port_three_pins_in(pins), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_bit(rsp_bit), .ext_code_stb(ext_code_stb),
        .ext_data_stb(ext_data_stb), .ext_addr(ext_addr), .active_bank(active_bank),
        .program_status_word(program_status_word), .timer_control_byte(timer_control_byte),
        .serial_control_byte(serial_control_byte), .interrupt_enable_mask(interrupt_enable_mask),
        .interrupt_level_select(interrupt_level_select), .port_one_latch(port_one_latch),
        .port_three_latch(port_three_latch), .port_three_pins_out(port_three_pins_out),
        .counter1_input(counter1_input), .counter0_input(counter0_input),
        .ext1_request_pin(ext1_request_pin), .ext0_request_pin(ext0_request_pin),
        .serial_rx_pin(serial_rx_pin));

    // ==========================================================
    // helpers
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.issue(DASD_DIRECT, 1'b1, 1'b0, a, d, 1'b0);
    endtask

    task automatic rd(input dasd_kind_e k, input logic psel, input logic [7:0] a,
                      input logic [2:0] f, input logic [7:0] e);
        notes.push_back('{f, k == DASD_BIT, e});
        core.issue(k, 1'b0, psel, a, 8'h00, 1'b0);
    endtask

    task automatic settle();
        core.release_bus();
        repeat (2) @(negedge core_clk);
    endtask

    // ==========================================================
    // answer watcher, oldest note first
    always @(negedge core_clk)
    begin
        if (rsp_valid === 1'b1 || ext_code_stb === 1'b1 || ext_data_stb === 1'b1)
        begin
            if (notes.size() == 0)
                check("unexpected answer", 64'h1, 64'h0);
            else
            begin
                note = notes.pop_front();
                seen = note.is_bit ? {7'h00, rsp_bit} : (note.flags[2] ? rsp_rdata : ext_addr);
                check("answer kind", {rsp_valid, ext_code_stb, ext_data_stb}, note.flags);
                check("answer value", seen, note.val);
            end
        end
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] p;
        int b;
        int i;
        nrst = 1'b0;
        fset = 6'h00;
        alt = 3'h7;
        pins = 8'hFF;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        check("reset bytes", {program_status_word, timer_control_byte, serial_control_byte,
            interrupt_enable_mask, interrupt_level_select, port_one_latch, port_three_latch,
            port_three_pins_out}, 64'h0000_0000_00FF_FFFF);
        for (b = 0; b < 4; b++)
        begin
            d = rnd();
            p = 8'h30 + 8'(b);
            wr(`DASD_STATUS_ADDR, 8'(b << 3));
            wr(8'(8 * b), p);
            wr(8'(8 * b + 1), p + 8'h10);
            wr(p, d);
            wr(p + 8'h10, ~d);
            rd(DASD_INDIRECT, 1'b0, 8'h00, RSP, d);
            rd(DASD_INDIRECT, 1'b1, 8'h00, RSP, ~d);
            // pointer rewritten right before use
            wr(8'(8 * b), p + 8'h10);
            rd(DASD_INDIRECT, 1'b0, 8'h00, RSP, ~d);
            settle();
            check("bank", active_bank, 64'(b));
        end
        d = rnd();
        wr(`DASD_STATUS_ADDR, 8'h00);
        wr(8'h00, 8'h90);
        wr(8'h10, d);
        wr(8'h7F, ~d);
        core.issue(DASD_INDIRECT, 1'b1, 1'b0, 8'h00, 8'h5A, 1'b0);
        rd(DASD_INDIRECT, 1'b0, 8'h00, RSP, `DASD_UNDEF_BYTE);
        rd(DASD_DIRECT, 1'b0, 8'h10, RSP, d);
        rd(DASD_DIRECT, 1'b0, 8'h7F, RSP, ~d);
        wr(8'h81, d);
        rd(DASD_DIRECT, 1'b0, 8'h81, RSP, `DASD_UNDEF_BYTE);
        settle();
        check("port one kept", port_one_latch, 8'hFF);
        for (i = 0; i < 6; i++)
        begin
            d = rnd() & RMASK[i];
            wr(RADDR[i], d);
            rd(DASD_DIRECT, 1'b0, RADDR[i], RSP, d);
        end
        settle();
        check("port one", port_one_latch, d);
        for (i = 0; i < 5; i++)
            for (b = 0; b < 8; b++)
                if (BMASK[i][b])
                begin
                    wr(BBASE[i], 8'h00);
                    core.issue(DASD_BIT, 1'b1, 1'b0, BBASE[i] + 8'(b), 8'h00, 1'b1);
                    rd(DASD_BIT, 1'b0, BBASE[i] + 8'(b), RSP, 8'h01);
                    rd(DASD_DIRECT, 1'b0, BBASE[i], RSP, 8'(1 << b));
                end
        for (i = 0; i < 4; i++)
        begin
            p = (i == 3) ? 8'h7F : (rnd() & 8'h7F);
            wr(8'h20 + 8'(p[6:3]), 8'h00);
            core.issue(DASD_BIT, 1'b1, 1'b0, p, 8'h00, 1'b1);
            rd(DASD_DIRECT, 1'b0, 8'h20 + 8'(p[6:3]), RSP, 8'(1 << p[2:0]));
        end
        for (i = 0; i < 6; i++)
        begin
            wr(`DASD_TMR_CTL_ADDR, 8'h00);
            wr(`DASD_SER_CTL_ADDR, 8'h00);
            settle();
            fset = 6'(1 << i);
            @(negedge core_clk);
            fset = 6'h00;
            @(negedge core_clk);
            check("flag set", {timer_control_byte, serial_control_byte},
                  64'(i < 2 ? 1 << i : 1 << (2 * i + 5)));
        end
        // hardware set against a same-cycle clearing write
        core.issue(DASD_DIRECT, 1'b1, 1'b0, `DASD_TMR_CTL_ADDR, 8'h00, 1'b0);
        fset = 6'h20;
        core.release_bus();
        fset = 6'h00;
        @(negedge core_clk);
        check("set wins", timer_control_byte, 8'h80);
        p = rnd();
        d = rnd();
        wr(8'h00, p);
        wr(8'h01, d);
        rd(DASD_CODE_TABLE_READ, 1'b1, 8'h00, CODE, d);
        rd(DASD_EXTERNAL_DATA_MOVE, 1'b0, 8'h00, XDM, p);
        for (i = 5; i < 8; i++)
            core.issue(3'(i), 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
        wr(`DASD_PORT_THREE_ADDR, 8'hFF);
        settle();
        for (i = 0; i < 4; i++)
        begin
            d = rnd();
            pins = ~d;
            alt = d[2:0];
            repeat (3) @(negedge core_clk);
            check("pin inputs", {counter1_input, counter0_input, ext1_request_pin,
                  ext0_request_pin, serial_rx_pin}, {pins[5:2], pins[0]});
            check("pin outputs", port_three_pins_out, {alt[2:1], 4'hF, alt[0], 1'b1});
        end
        check("notes drained", 64'(notes.size()), 64'h0);
        summarize();
    end
endmodule
`default_nettype wire
